// ---- design/bkt_pkg.sv ----
package bkt_pkg;
  // register addresses on the internal register port
  localparam logic [7:0] MAIN_ADDR = 8'h3B;
  localparam logic [7:0] LIMIT_ADDR = 8'h3C;
  // main control field positions
  localparam int RUN_EN_BIT = 0;
  localparam int STBY_EN_BIT = 1;
  localparam int SLEEP_EN_BIT = 2;
  localparam int LOW_PWR_BIT = 3;
  localparam int SLEW_BIT = 4;
  localparam int RAMP_DOWN_BIT = 5;
  localparam int FORCED_MOD_BIT = 6;
  localparam int DISCHARGE_BIT = 7;
  // limit and timing field positions
  localparam int ILIM_LSB = 0;
  localparam int TIMING_BIT = 4;
  // writable mask of the limit and timing register
  localparam logic [7:0] LIMIT_MASK = 8'h13;
  // values after reset
  localparam logic [7:0] MAIN_RESET = 8'h00;
  localparam logic [7:0] LIMIT_RESET = 8'h00;
  // fuse-loaded bits of each register
  localparam logic [7:0] MAIN_FUSE_MASK = 8'h93;
  localparam logic [7:0] LIMIT_FUSE_MASK = 8'h03;
  // operating modes of the device
  typedef enum logic [2:0] {
    BKT_RUN = 3'h1,
    BKT_STANDBY = 3'h2,
    BKT_SLEEP = 3'h4
  } bkt_mode_t;
endpackage

// ---- design/bkt_reg8.sv ----
`timescale 1ns/100ps
// one eight-bit register with fuse load, software write and async-style set
module bkt_reg8 #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WR_MASK = 8'hFF,
  parameter logic [7:0] FUSE_MASK = 8'hFF
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic fuse_load_i,
  input wire logic [7:0] fuse_val_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] set_i,
  output logic [7:0] q_o
);
  logic [7:0] q_q; // stored value
  logic [7:0] q_d; // next value

  // fuse load first, then software write, device set wins over both
  always_comb
  begin
    q_d = q_q;
    if (fuse_load_i)
    begin
      q_d = (q_q & ~FUSE_MASK) | (fuse_val_i & FUSE_MASK); // RQ12
    end
    if (wr_i)
    begin
      q_d = wdata_i & WR_MASK; // RQ14
    end
    q_d = (q_d | set_i) & WR_MASK; // RQ13
  end

  // register stage
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      q_q <= RESET_VAL;
    end
    else
    begin
      q_q <= q_d;
    end
  end

  assign q_o = q_q;
endmodule

// ---- design/bkt_ctrl_regs.sv ----
`timescale 1ns/100ps
// Behaviour
// RQ1 - bit0 enables regulator in run mode
// RQ2 - bit1 enables regulator in standby mode
// RQ3 - bit2 enables regulator in sleep mode
// RQ4 - bit3 selects low power in standby/sleep
// RQ5 - bit4 slew: 0 fast, 1 slow
// RQ6 - slew bit ignored when fuse select set
// RQ7 - bit5 forces continuous conduction ramping down
// RQ8 - bit6 forces pulse-width modulation
// RQ9 - bit7 controls discharge resistor when disabled
// RQ10 - second register bits1:0 select current limit
// RQ11 - second register bit4 selects timing scheme
// RQ12 - fuse fields load, stay software accessible
// RQ13 - async-set fields settable by device, software rw
// RQ14 - unused second register bits read zero
module bkt_ctrl_regs (
  input wire logic clk_i,
  input wire logic reset_i,
  // register port of the serial control interface
  input wire logic [7:0] addr_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  // fuse load strobe and fuse contents
  input wire logic fuse_load_i,
  input wire logic [7:0] fuse_main_i,
  input wire logic [7:0] fuse_limit_i,
  input wire logic first_buck_run_enable_i,
  input wire logic fuse_scaling_select_i,
  // device-side sets of async-set bits
  input wire logic [7:0] set_main_i,
  input wire logic [7:0] set_limit_i,
  // current device mode, one-hot
  input wire logic [2:0] mode_i,
  input wire logic ramp_down_i,
  // regulator controls
  output logic reg_enable_o,
  output logic low_power_o,
  output logic scaling_slew_select_o,
  output logic slew_active_o,
  output logic forced_modulation_o,
  output logic discharge_on_o,
  output logic [1:0] current_limit_select_o,
  output logic timing_scheme_select_o
);
  logic [7:0] main_q; // main control contents
  logic [7:0] limit_q; // limit and timing contents
  logic [7:0] fuse_main; // fuse image of main control
  logic wr_main; // write to main control
  logic wr_limit; // write to limit register
  logic [7:0] rdata_d; // next read data
  logic [7:0] rdata_q; // registered read data
  logic enable_d; // next enable
  logic enable_q; // registered enable
  logic lp_d; // next low power request
  logic lp_q; // registered low power request
  logic fm_d; // next forced modulation
  logic fm_q; // registered forced modulation
  logic dis_d; // next discharge resistor state
  logic dis_q; // registered discharge resistor state
  logic slew_d; // next slew-active flag
  logic slew_q; // registered slew-active flag
  logic mode_none; // no legal mode selected, checks only

  // standby enable defaults to the first buck run enable fuse
  always_comb
  begin
    fuse_main = fuse_main_i;
    fuse_main[bkt_pkg::STBY_EN_BIT] = first_buck_run_enable_i; // RQ2
  end

  // address decode
  assign wr_main = wr_i && (addr_i == bkt_pkg::MAIN_ADDR);
  assign wr_limit = wr_i && (addr_i == bkt_pkg::LIMIT_ADDR);
  // mode code that is neither run, standby nor sleep
  assign mode_none = (mode_i != bkt_pkg::BKT_RUN) && (mode_i != bkt_pkg::BKT_STANDBY)
    && (mode_i != bkt_pkg::BKT_SLEEP);

  // main control register
  bkt_reg8 #(
    .RESET_VAL(bkt_pkg::MAIN_RESET),
    .WR_MASK(8'hFF),
    .FUSE_MASK(bkt_pkg::MAIN_FUSE_MASK)
  ) u_main (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .fuse_load_i(fuse_load_i),
    .fuse_val_i(fuse_main), // RQ12
    .wr_i(wr_main),
    .wdata_i(wdata_i),
    .set_i(set_main_i & bkt_pkg::MAIN_FUSE_MASK), // RQ13
    .q_o(main_q)
  );

  // limit and timing register
  bkt_reg8 #(
    .RESET_VAL(bkt_pkg::LIMIT_RESET),
    .WR_MASK(bkt_pkg::LIMIT_MASK),
    .FUSE_MASK(bkt_pkg::LIMIT_FUSE_MASK)
  ) u_limit (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .fuse_load_i(fuse_load_i),
    .fuse_val_i(fuse_limit_i), // RQ12
    .wr_i(wr_limit),
    .wdata_i(wdata_i),
    .set_i(set_limit_i & bkt_pkg::LIMIT_FUSE_MASK), // RQ13
    .q_o(limit_q)
  );

  // read mux and regulator controls
  always_comb
  begin
    case (addr_i)
      bkt_pkg::MAIN_ADDR: rdata_d = main_q;
      bkt_pkg::LIMIT_ADDR: rdata_d = limit_q & bkt_pkg::LIMIT_MASK; // RQ14
      default: rdata_d = 8'h00;
    endcase
    // enable chosen by current mode
    case (mode_i)
      bkt_pkg::BKT_RUN: enable_d = main_q[bkt_pkg::RUN_EN_BIT]; // RQ1
      bkt_pkg::BKT_STANDBY: enable_d = main_q[bkt_pkg::STBY_EN_BIT]; // RQ2
      bkt_pkg::BKT_SLEEP: enable_d = main_q[bkt_pkg::SLEEP_EN_BIT]; // RQ3
      default: enable_d = 1'b0;
    endcase
    // low power only in standby and sleep, never in run or with no mode
    lp_d = main_q[bkt_pkg::LOW_PWR_BIT] // RQ4
      && (mode_i == bkt_pkg::BKT_STANDBY || mode_i == bkt_pkg::BKT_SLEEP);
    // slew select counts only while the fuse leaves scaling to software
    slew_d = !fuse_scaling_select_i; // RQ6
    // forced modulation, always or during ramp down
    fm_d = main_q[bkt_pkg::FORCED_MOD_BIT] // RQ8
      || (main_q[bkt_pkg::RAMP_DOWN_BIT] && ramp_down_i); // RQ7
    // discharge resistor only while disabled
    dis_d = main_q[bkt_pkg::DISCHARGE_BIT] && !enable_d; // RQ9
  end

  // output registers
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rdata_q <= 8'h00;
      enable_q <= 1'b0;
      lp_q <= 1'b0;
      fm_q <= 1'b0;
      dis_q <= 1'b0;
      slew_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      enable_q <= enable_d;
      lp_q <= lp_d;
      fm_q <= fm_d;
      dis_q <= dis_d;
      slew_q <= slew_d;
    end
  end

  assign rdata_o = rdata_q;
  assign reg_enable_o = enable_q;
  assign low_power_o = lp_q;
  assign forced_modulation_o = fm_q;
  assign discharge_on_o = dis_q;
  assign scaling_slew_select_o = main_q[bkt_pkg::SLEW_BIT]; // RQ5
  assign slew_active_o = slew_q; // RQ6
  assign current_limit_select_o = limit_q[bkt_pkg::ILIM_LSB +: 2]; // RQ10
  assign timing_scheme_select_o = limit_q[bkt_pkg::TIMING_BIT]; // RQ11

  // run enable follows bit 0 in run mode
  run_enable_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ1
    mode_i == bkt_pkg::BKT_RUN |=> reg_enable_o == $past(main_q[0]))
    else $error("run enable mismatch");
  // standby enable follows bit 1
  stby_enable_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ2
    mode_i == bkt_pkg::BKT_STANDBY |=> reg_enable_o == $past(main_q[1]))
    else $error("standby enable mismatch");
  // sleep enable follows bit 2
  sleep_enable_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ3
    mode_i == bkt_pkg::BKT_SLEEP |=> reg_enable_o == $past(main_q[2]))
    else $error("sleep enable mismatch");
  // no low power in run mode
  low_power_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ4
    mode_i == bkt_pkg::BKT_RUN |=> !low_power_o)
    else $error("low power in run");
  // written slew bit appears next cycle
  slew_write_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ5
    wr_main && !fuse_load_i && set_main_i == 8'h00
    |=> scaling_slew_select_o == $past(wdata_i[4]))
    else $error("slew select not written");
  // slew inactive when fuse select is one
  slew_gate_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ6
    fuse_scaling_select_i |=> !slew_active_o)
    else $error("slew active under fuse select");
  // discharge never while enabled
  discharge_off_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ9
    reg_enable_o |-> !discharge_on_o)
    else $error("discharge while enabled");
  // forced modulation bit forces output
  forced_mod_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ8
    main_q[6] |=> forced_modulation_o)
    else $error("forced modulation missing");
  // unused bits of limit register read zero
  unused_zero_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ14
    (limit_q & 8'hEC) == 8'h00)
    else $error("unused limit bits set");
  // no legal mode means the regulator stays off
  mode_off_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ1
    mode_none |=> !reg_enable_o)
    else $error("enable without a mode");
  // a plain write replaces the whole main register
  main_write_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ1
    wr_main && !fuse_load_i && set_main_i == 8'h00 |=> main_q == $past(wdata_i))
    else $error("main register not written");
  // standby enable is seeded from the first buck run enable fuse
  fuse_stby_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ2
    fuse_load_i && !wr_main && set_main_i == 8'h00
    |=> main_q[bkt_pkg::STBY_EN_BIT] == $past(first_buck_run_enable_i))
    else $error("standby enable not seeded");
  // low power follows its bit in standby
  lp_standby_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ4
    mode_i == bkt_pkg::BKT_STANDBY |=> low_power_o == $past(main_q[bkt_pkg::LOW_PWR_BIT]))
    else $error("low power wrong in standby");
  // low power follows its bit in sleep
  lp_sleep_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ4
    mode_i == bkt_pkg::BKT_SLEEP |=> low_power_o == $past(main_q[bkt_pkg::LOW_PWR_BIT]))
    else $error("low power wrong in sleep");
  // no low power without a legal mode
  lp_none_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ4
    mode_none |=> !low_power_o)
    else $error("low power without a mode");
  // fuse load seeds the slew select
  slew_fuse_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ5
    fuse_load_i && !wr_main && set_main_i == 8'h00
    |=> scaling_slew_select_o == $past(fuse_main_i[bkt_pkg::SLEW_BIT]))
    else $error("slew select not seeded");
  // slew select active while the fuse select is zero
  slew_free_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ6
    !fuse_scaling_select_i |=> slew_active_o)
    else $error("slew inactive without fuse select");
  // ramp down with its bit set forces modulation
  ramp_force_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ7
    main_q[bkt_pkg::RAMP_DOWN_BIT] && ramp_down_i |=> forced_modulation_o)
    else $error("ramp down not forced");
  // no ramp and no force bit leaves modulation free
  ramp_idle_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ7
    !ramp_down_i && !main_q[bkt_pkg::FORCED_MOD_BIT] |=> !forced_modulation_o)
    else $error("forced outside ramp down");
  // both force bits clear leaves modulation free
  force_off_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ8
    !main_q[bkt_pkg::FORCED_MOD_BIT] && !main_q[bkt_pkg::RAMP_DOWN_BIT]
    |=> !forced_modulation_o)
    else $error("forced modulation without a bit");
  // disabled in run with the bit set connects the resistor
  discharge_on_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ9
    main_q[bkt_pkg::DISCHARGE_BIT] && !main_q[bkt_pkg::RUN_EN_BIT]
    && mode_i == bkt_pkg::BKT_RUN |=> discharge_on_o)
    else $error("discharge missing while disabled");
  // bit clear keeps the resistor off
  discharge_idle_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ9
    !main_q[bkt_pkg::DISCHARGE_BIT] |=> !discharge_on_o)
    else $error("discharge with bit clear");
  // written current limit appears next cycle
  limit_write_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ10
    wr_limit && !fuse_load_i && set_limit_i == 8'h00
    |=> current_limit_select_o == $past(wdata_i[1:0]))
    else $error("current limit not written");
  // limit register holds without write, load or set
  hold_limit_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ10
    !wr_limit && !fuse_load_i && set_limit_i == 8'h00 |=> $stable(limit_q))
    else $error("limit register changed");
  // written timing scheme appears next cycle
  timing_write_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ11
    wr_limit |=> timing_scheme_select_o == $past(wdata_i[bkt_pkg::TIMING_BIT]))
    else $error("timing scheme not written");
  // timing scheme changes only by a write
  timing_keep_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ11
    !wr_limit |=> $stable(timing_scheme_select_o))
    else $error("timing scheme changed");
  // fuse load seeds run, slew and discharge bits
  fuse_main_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ12
    fuse_load_i && !wr_main && set_main_i == 8'h00
    |=> (main_q & 8'h91) == $past(fuse_main_i & 8'h91))
    else $error("main fuse bits not loaded");
  // fuse load keeps the software-only bits
  fuse_keep_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ12
    fuse_load_i && !wr_main && set_main_i == 8'h00
    |=> (main_q & ~bkt_pkg::MAIN_FUSE_MASK) == $past(main_q & ~bkt_pkg::MAIN_FUSE_MASK))
    else $error("fuse load touched other bits");
  // fuse load seeds the current limit
  fuse_limit_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ12
    fuse_load_i && !wr_limit && set_limit_i == 8'h00
    |=> current_limit_select_o == $past(fuse_limit_i[1:0]))
    else $error("limit fuse bits not loaded");
  // main register holds without write, load or set
  hold_main_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ12
    !wr_main && !fuse_load_i && set_main_i == 8'h00 |=> $stable(main_q))
    else $error("main register changed");
  // main register reads back one cycle later
  read_main_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ12
    addr_i == bkt_pkg::MAIN_ADDR |=> rdata_o == $past(main_q))
    else $error("main read data wrong");
  // device set wins on the main register
  main_set_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ13
    set_main_i != 8'h00 |=> (main_q & $past(set_main_i & bkt_pkg::MAIN_FUSE_MASK))
    == $past(set_main_i & bkt_pkg::MAIN_FUSE_MASK))
    else $error("main set lost");
  // device set wins on the limit register
  limit_set_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ13
    set_limit_i != 8'h00 |=> (limit_q & $past(set_limit_i & bkt_pkg::LIMIT_FUSE_MASK))
    == $past(set_limit_i & bkt_pkg::LIMIT_FUSE_MASK))
    else $error("limit set lost");
  // limit register reads back one cycle later
  read_limit_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ14
    addr_i == bkt_pkg::LIMIT_ADDR |=> rdata_o == $past(limit_q))
    else $error("limit read data wrong");
  // unmapped addresses read zero
  read_other_a: assert property (@(posedge clk_i) disable iff (reset_i) // RQ14
    addr_i != bkt_pkg::MAIN_ADDR && addr_i != bkt_pkg::LIMIT_ADDR |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
endmodule

// ---- sim/bkt_ctrl_regs_bench.sv ----
`timescale 1ns/100ps
// register bank bench: bus writes and reads, fuse load, device sets, outputs per mode
module bkt_ctrl_regs_bench;
  logic clk_i = 1'b0; // 125 mhz clock
  logic reset_i = 1'b1; // sync reset
  logic [7:0] adr = 8'h00; // register address
  logic wr = 1'b0; // write strobe
  logic [7:0] wd = 8'h00; // write data
  logic fld = 1'b0; // fuse load pulse
  logic [7:0] fm = 8'h00; // fuse main
  logic [7:0] fl = 8'h00; // fuse limit
  logic fb = 1'b0; // first buck run enable
  logic fs = 1'b0; // fuse scaling select
  logic [7:0] sm = 8'h00; // device set main
  logic [7:0] sl = 8'h00; // device set limit
  logic [2:0] md = 3'h1; // device mode
  logic rp = 1'b0; // ramp down
  logic [7:0] rdata; // read data
  logic [8:0] outs; // packed regulator controls
  logic [7:0] m; // expected main register
  logic [7:0] l; // expected limit register
  logic look_r = 1'b0; // read result due
  logic look_o = 1'b0; // output check due
  logic [8:0] rq[$]; // expected read data
  logic [8:0] oq[$]; // expected controls
  logic [2:0] modes[4] = '{3'h1, 3'h2, 3'h4, 3'h0}; // every mode plus none
  int err_total = 0; // mismatches
  int n_checks = 0; // comparisons
  // device under test
  bkt_ctrl_regs i_dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(adr), .wr_i(wr),
    .wdata_i(wd), .rdata_o(rdata), .fuse_load_i(fld), .fuse_main_i(fm),
    .fuse_limit_i(fl), .first_buck_run_enable_i(fb), .fuse_scaling_select_i(fs),
    .set_main_i(sm), .set_limit_i(sl), .mode_i(md), .ramp_down_i(rp),
    .reg_enable_o(outs[8]), .low_power_o(outs[7]), .forced_modulation_o(outs[6]),
    .discharge_on_o(outs[5]), .scaling_slew_select_o(outs[4]),
    .slew_active_o(outs[3]), .timing_scheme_select_o(outs[2]),
    .current_limit_select_o(outs[1:0]));
  // clock generator
  initial
  begin
    forever #4 clk_i = ~clk_i;
  end
  // compare seen against expected
  task check(input logic [8:0] seen, input logic [8:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // expected controls from registers and device state
  function logic [8:0] eo();
    logic en;
    en = (md == 3'h1 & m[0]) | (md == 3'h2 & m[1]) | (md == 3'h4 & m[2]);
    eo = {en, m[3] & (md == 3'h2 | md == 3'h4), m[6] | (m[5] & rp), m[7] & !en,
      m[4], !fs, l[4], l[1:0]};
  endfunction
  // one register write
  task wrt(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    adr = a;
    wd = d;
    wr = 1'b1;
    @(negedge clk_i);
    wr = 1'b0;
  endtask
  // one register read, expectation noted for the monitor
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_i);
    adr = a;
    rq.push_back({1'b0, e});
    look_r = 1'b1;
    @(negedge clk_i);
    look_r = 1'b0;
  endtask
  // controls checked once settled
  task ou();
    repeat (2) @(negedge clk_i);
    oq.push_back(eo());
    look_o = 1'b1;
    @(negedge clk_i);
    look_o = 1'b0;
  endtask
  // monitor takes oldest note whenever a result is due
  always @(posedge clk_i)
  begin
    #1;
    if (look_r)
      check({1'b0, rdata}, rq.pop_front());
    if (look_o)
      check(outs, oq.pop_front());
  end
  // verdict and end of run
  task end_of_test();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    end_of_test();
  end
  // main sequence
  initial
  begin
    void'($urandom(46833));
    repeat (16) @(negedge clk_i);
    reset_i = 1'b0;
    rd(8'h3B, 8'h00);
    rd(8'h3C, 8'h00);
    // fuse load of random contents
    fm = 8'($urandom);
    fl = 8'($urandom);
    fb = 1'($urandom);
    fld = 1'b1;
    @(negedge clk_i);
    fld = 1'b0;
    m = (fm & 8'h91) | {6'h00, fb, 1'b0};
    l = fl & 8'h03;
    rd(8'h3B, m);
    rd(8'h3C, l);
    ou();
    // random writes across every mode and limit code
    for (int i = 0; i < 16; i++)
    begin
      md = modes[i % 4];
      rp = 1'($urandom);
      fs = 1'($urandom);
      m = 8'($urandom);
      l = {6'($urandom), 2'(i / 4)};
      wrt(8'h3B, m);
      wrt(8'h3C, l);
      l = l & 8'h13;
      rd(8'h3B, m);
      rd(8'h3C, l);
      ou();
    end
    // unmapped address is ignored and reads zero
    wrt(8'h3D, 8'hFF);
    rd(8'h3D, 8'h00);
    rd(8'h3B, m);
    // device set wins over a clearing write
    sm = 8'hFF;
    sl = 8'hFF;
    wrt(8'h3B, 8'h00);
    wrt(8'h3C, 8'h00);
    sm = 8'h00;
    sl = 8'h00;
    m = 8'h93;
    l = 8'h03;
    rd(8'h3B, m);
    rd(8'h3C, l);
    ou();
    // mid-run reset clears both registers and every control but slew active, which follows the fuse select
    reset_i = 1'b1;
    repeat (3) @(negedge clk_i);
    reset_i = 1'b0;
    m = 8'h00;
    l = 8'h00;
    rd(8'h3B, m);
    rd(8'h3C, l);
    ou();
    end_of_test();
  end
endmodule
